// >>> hdl/hpc_pkg.sv
// Purpose: shared constants and types for the hub port configuration bank
// Assumes: 8-bit configuration bytes loaded by an external source
// Notes:   all offsets, field positions, masks and reset values live here
package hpc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] HPC_ADDR_ASSIGN_LED = 8'h08;
	localparam logic [7:0] HPC_ADDR_FIXED_DEV  = 8'h09;
	localparam logic [7:0] HPC_ADDR_SP_OFF     = 8'h0A;
	localparam logic [7:0] HPC_ADDR_BP_OFF     = 8'h0B;

	// ----------------------------------------------------------------
	// reset values and writable bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0] HPC_RESET_VALUE     = 8'h00;
	localparam logic [7:0] HPC_MASK_ASSIGN_LED = 8'hE7;
	localparam logic [7:0] HPC_MASK_PORTS      = 8'h1E;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int HPC_STYLE_HI     = 7;
	localparam int HPC_STYLE_LO     = 6;
	localparam int HPC_SOURCE_BIT   = 5;
	localparam int HPC_IND_HI       = 2;
	localparam int HPC_IND_LO       = 1;
	localparam int HPC_STRING_BIT   = 0;
	localparam int HPC_PORT_HI      = 4;
	localparam int HPC_PORT_LO      = 1;
	localparam int HPC_NUM_PORTS    = 4;
	localparam int HPC_PRESET_W     = 3;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HPC_STYLE_PRESET3   = 2'b00,
		HPC_STYLE_LEVEL4    = 2'b01,
		HPC_STYLE_EDGE4     = 2'b10,
		HPC_STYLE_EDGE4_UNA = 2'b11
	} hpc_style_t;

	typedef enum logic [1:0] {
		HPC_IND_USB         = 2'b00,
		HPC_IND_OWNER_SPEED = 2'b01,
		HPC_IND_OWNER_BASIC = 2'b10
	} hpc_ind_t;

	// strap decodes for the internal default option
	localparam logic [3:0] HPC_FIXED_STRAP_0 = 4'h0;
	localparam logic [3:0] HPC_FIXED_STRAP_1 = 4'h1;
	localparam logic [3:0] HPC_FIXED_STRAP_2 = 4'h3;
	localparam logic [3:0] HPC_FIXED_STRAP_3 = 4'h7;
	localparam logic [3:0] HPC_OFF_STRAP_0   = 4'h0;
	localparam logic [3:0] HPC_OFF_STRAP_1   = 4'h8;
	localparam logic [3:0] HPC_OFF_STRAP_2   = 4'hC;
	localparam logic [3:0] HPC_OFF_STRAP_3   = 4'hE;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} hpc_wr_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
	} hpc_rd_t;

endpackage

// >>> hdl/hpc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static relative to REF_CLK
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module hpc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// >>> hdl/hpc_owner_cell.sv
// Purpose: ownership state of one downstream port driven by its select pin
// Assumes: sel is already synchronised to clk
// Notes:   host 0 is the first upstream host, 1 the second
`timescale 1ns/1ps
module hpc_owner_cell
	import hpc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] style,
	input  wire logic       pins_active,
	input  wire logic       sel,
	output logic            assigned,
	output logic            host
);
	logic sel_prev_reg;
	logic rise;

	assign rise = sel & ~sel_prev_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_prev_reg <= 1'b0;
		end else begin
			sel_prev_reg <= sel;
		end
	end

	// frozen while registers own the assignment or in preset mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			assigned <= 1'b1;
			host     <= 1'b0;
		end else if (pins_active) begin
			unique case (style)
				HPC_STYLE_PRESET3: begin
					assigned <= assigned;
				end
				HPC_STYLE_LEVEL4: begin
					assigned <= 1'b1;
					host     <= sel;
				end
				HPC_STYLE_EDGE4: begin
					assigned <= 1'b1;
					if (rise) begin
						host <= ~host;
					end
				end
				HPC_STYLE_EDGE4_UNA: begin
					// cycle: first host, second host, unassigned
					if (rise) begin
						if (!assigned) begin
							assigned <= 1'b1;
							host     <= 1'b0;
						end else if (!host) begin
							host <= 1'b1;
						end else begin
							assigned <= 1'b0;
							host     <= 1'b0;
						end
					end
				end
			endcase
		end
	end
endmodule

// >>> hdl/hpc_top.sv
// Purpose: configuration byte bank 08h..0Bh and its decoded outputs
// Assumes: write and read strobes come from logic on REF_CLK
// Notes:   straps are captured once, after both synchroniser stages fill
`timescale 1ns/1ps
module hpc_top
	import hpc_pkg::*;
(
	input  wire logic                 REF_CLK,
	input  wire logic                 RST,
	input  wire hpc_pkg::hpc_wr_t     CFG_WR,
	input  wire hpc_pkg::hpc_rd_t     CFG_RD,
	input  wire logic                 CFG_DONE,
	input  wire logic                 USE_DEFAULTS,
	input  wire logic [1:0]           FIXED_DEVICE_STRAPS,
	input  wire logic [1:0]           PORT_OFF_STRAPS,
	input  wire logic                 LOCAL_POWER_PRESENT,
	input  wire logic [3:0]           ASSIGN_PINS,
	output logic      [7:0]           CFG_RDATA,
	output logic                      CFG_RVALID,
	output logic      [2:0]           PRESET_SEL,
	output logic      [3:0]           PORT_ASSIGNED,
	output logic      [3:0]           PORT_HOST,
	output logic                      OWNER_FROM_REGS,
	output logic      [1:0]           INDICATOR_SCHEME,
	output logic                      STRING_ENABLE,
	output logic      [3:0]           FIXED_DEVICE_PORTS,
	output logic      [3:0]           PORT_OFF,
	output logic                      SELF_POWERED,
	output logic                      ATTACH_ALLOWED
);
	import hpc_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] assign_led_string_config_reg;
	logic [7:0] fixed_device_port_mask_reg;
	logic [7:0] self_powered_port_off_mask_reg;
	logic [7:0] bus_powered_port_off_mask_reg;
	logic       applied_reg;
	logic       strap_taken_reg;
	logic [1:0] fixed_strap_reg;
	logic [1:0] off_strap_reg;
	logic [3:0] sel_sync;
	logic       local_sync;
	logic       defaults_sync;
	logic [1:0] fixed_strap_sync;
	logic [1:0] off_strap_sync;
	logic       sync_ready;
	logic [1:0] ownership_interface_style;
	logic       ownership_source_select;
	logic [1:0] indicator_scheme;
	logic [3:0] fixed_strap_mask;
	logic [3:0] off_strap_mask;
	logic       pins_active;
	logic       wr_hit;

	assign ownership_interface_style =
		assign_led_string_config_reg[HPC_STYLE_HI:HPC_STYLE_LO];
	assign ownership_source_select =
		assign_led_string_config_reg[HPC_SOURCE_BIT];
	assign indicator_scheme =
		assign_led_string_config_reg[HPC_IND_HI:HPC_IND_LO];
	assign pins_active = ~ownership_source_select;
	// loading is refused once the configuration has been applied
	assign wr_hit = CFG_WR.en & ~applied_reg;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// constant one marks when straps have crossed both stages
	hpc_sync #(.WIDTH(11)) u_sync (
		.clk (REF_CLK),
		.rst (RST),
		.d   ({ASSIGN_PINS, LOCAL_POWER_PRESENT, USE_DEFAULTS,
		       FIXED_DEVICE_STRAPS, PORT_OFF_STRAPS, 1'b1}),
		.q   ({sel_sync, local_sync, defaults_sync,
		       fixed_strap_sync, off_strap_sync, sync_ready})
	);

	// ----------------------------------------------------------------
	// configuration load
	// ----------------------------------------------------------------
	// reset to zero
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			assign_led_string_config_reg   <= HPC_RESET_VALUE;
			fixed_device_port_mask_reg     <= HPC_RESET_VALUE;
			self_powered_port_off_mask_reg <= HPC_RESET_VALUE;
			bus_powered_port_off_mask_reg  <= HPC_RESET_VALUE;
		end else if (wr_hit) begin
			unique case (CFG_WR.addr)
				HPC_ADDR_ASSIGN_LED: begin
					assign_led_string_config_reg <=
						CFG_WR.data & HPC_MASK_ASSIGN_LED;
				end
				HPC_ADDR_FIXED_DEV: begin
					fixed_device_port_mask_reg <= CFG_WR.data & HPC_MASK_PORTS;
				end
				HPC_ADDR_SP_OFF: begin
					self_powered_port_off_mask_reg <=
						CFG_WR.data & HPC_MASK_PORTS;
				end
				HPC_ADDR_BP_OFF: begin
					bus_powered_port_off_mask_reg <=
						CFG_WR.data & HPC_MASK_PORTS;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			applied_reg    <= 1'b0;
			ATTACH_ALLOWED <= 1'b0;
		end else begin
			if (CFG_DONE) begin
				applied_reg <= 1'b1;
			end
			ATTACH_ALLOWED <= applied_reg;
		end
	end

	// ----------------------------------------------------------------
	// readback
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			CFG_RDATA  <= HPC_RESET_VALUE;
			CFG_RVALID <= 1'b0;
		end else begin
			CFG_RVALID <= CFG_RD.en;
			if (CFG_RD.en) begin
				unique case (CFG_RD.addr)
					HPC_ADDR_ASSIGN_LED: CFG_RDATA <= assign_led_string_config_reg;
					HPC_ADDR_FIXED_DEV:  CFG_RDATA <= fixed_device_port_mask_reg;
					HPC_ADDR_SP_OFF:     CFG_RDATA <= self_powered_port_off_mask_reg;
					HPC_ADDR_BP_OFF:     CFG_RDATA <= bus_powered_port_off_mask_reg;
					default:             CFG_RDATA <= HPC_RESET_VALUE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	// capture waits for sync_ready so reset zeros are never latched
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			strap_taken_reg <= 1'b0;
			fixed_strap_reg <= 2'b00;
			off_strap_reg   <= 2'b00;
		end else if (sync_ready && !strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			fixed_strap_reg <= fixed_strap_sync;
			off_strap_reg   <= off_strap_sync;
		end
	end

	always_comb begin
		unique case (fixed_strap_reg)
			2'b00: fixed_strap_mask = HPC_FIXED_STRAP_0;
			2'b01: fixed_strap_mask = HPC_FIXED_STRAP_1;
			2'b10: fixed_strap_mask = HPC_FIXED_STRAP_2;
			2'b11: fixed_strap_mask = HPC_FIXED_STRAP_3;
		endcase
		unique case (off_strap_reg)
			2'b00: off_strap_mask = HPC_OFF_STRAP_0;
			2'b01: off_strap_mask = HPC_OFF_STRAP_1;
			2'b10: off_strap_mask = HPC_OFF_STRAP_2;
			2'b11: off_strap_mask = HPC_OFF_STRAP_3;
		endcase
	end

	// ----------------------------------------------------------------
	// decoded port masks
	// ----------------------------------------------------------------
	// straps replace loaded mask
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			FIXED_DEVICE_PORTS <= 4'h0;
		end else if (defaults_sync) begin
			FIXED_DEVICE_PORTS <= fixed_strap_mask;
		end else begin
			FIXED_DEVICE_PORTS <=
				fixed_device_port_mask_reg[HPC_PORT_HI:HPC_PORT_LO];
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			SELF_POWERED <= 1'b0;
			PORT_OFF     <= 4'h0;
		end else begin
			SELF_POWERED <= local_sync;
			if (defaults_sync) begin
				PORT_OFF <= off_strap_mask;
			end else if (local_sync) begin
				PORT_OFF <=
					self_powered_port_off_mask_reg[HPC_PORT_HI:HPC_PORT_LO];
			end else begin
				PORT_OFF <=
					bus_powered_port_off_mask_reg[HPC_PORT_HI:HPC_PORT_LO];
			end
		end
	end

	// ----------------------------------------------------------------
	// indicator, string and source decode
	// ----------------------------------------------------------------
	// 11 folds onto usb scheme
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			INDICATOR_SCHEME <= HPC_IND_USB;
			STRING_ENABLE    <= 1'b0;
			OWNER_FROM_REGS  <= 1'b0;
		end else begin
			unique case (indicator_scheme)
				2'b01:   INDICATOR_SCHEME <= HPC_IND_OWNER_SPEED;
				2'b10:   INDICATOR_SCHEME <= HPC_IND_OWNER_BASIC;
				default: INDICATOR_SCHEME <= HPC_IND_USB;
			endcase
			STRING_ENABLE <= assign_led_string_config_reg[HPC_STRING_BIT];
			OWNER_FROM_REGS <= ownership_source_select;
		end
	end

	// ----------------------------------------------------------------
	// port assignment interface
	// ----------------------------------------------------------------
	// three-wire preset select
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			PRESET_SEL <= 3'h0;
		end else if (pins_active &&
		             ownership_interface_style == HPC_STYLE_PRESET3) begin
			PRESET_SEL <= sel_sync[HPC_PRESET_W-1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < HPC_NUM_PORTS; gi++) begin : g_port
			hpc_owner_cell u_cell (
				.clk         (REF_CLK),
				.rst         (RST),
				.style       (ownership_interface_style),
				.pins_active (pins_active),
				.sel         (sel_sync[gi]),
				.assigned    (PORT_ASSIGNED[gi]),
				.host        (PORT_HOST[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_load_sp;
		wr_hit && CFG_WR.addr == HPC_ADDR_SP_OFF;
	endsequence

	sequence s_sp_used;
		!defaults_sync && local_sync && !wr_hit;
	endsequence

	a_preset_follow: assert property (@(posedge REF_CLK) disable iff (RST)
		pins_active && ownership_interface_style == HPC_STYLE_PRESET3
		|=> PRESET_SEL == $past(sel_sync[2:0]))
		else $error("preset select not following pins");

	a_level_follow: assert property (@(posedge REF_CLK) disable iff (RST)
		pins_active && ownership_interface_style == HPC_STYLE_LEVEL4
		|=> PORT_ASSIGNED == 4'hF && PORT_HOST == $past(sel_sync))
		else $error("level mode owner wrong");

	a_edge_assigned: assert property (@(posedge REF_CLK) disable iff (RST)
		pins_active && ownership_interface_style == HPC_STYLE_EDGE4
		|=> PORT_ASSIGNED == 4'hF)
		else $error("port unassigned in edge mode 10");

	a_edge_toggle: assert property (@(posedge REF_CLK) disable iff (RST)
		pins_active && ownership_interface_style == HPC_STYLE_EDGE4
		&& $past(ownership_interface_style) == HPC_STYLE_EDGE4
		&& sel_sync[0] && !$past(sel_sync[0])
		|=> PORT_HOST[0] != $past(PORT_HOST[0]))
		else $error("edge did not toggle port owner");

	a_una_cycle: assert property (@(posedge REF_CLK) disable iff (RST)
		pins_active && ownership_interface_style == HPC_STYLE_EDGE4_UNA
		&& PORT_ASSIGNED[0] && PORT_HOST[0]
		&& sel_sync[0] && !$past(sel_sync[0])
		|=> !PORT_ASSIGNED[0])
		else $error("unassigned state not entered");

	a_regs_freeze: assert property (@(posedge REF_CLK) disable iff (RST)
		ownership_source_select |=> $stable(PORT_HOST) && OWNER_FROM_REGS)
		else $error("pins changed owner under register control");

	a_ind_decode: assert property (@(posedge REF_CLK) disable iff (RST)
		indicator_scheme == 2'b11 |=> INDICATOR_SCHEME == HPC_IND_USB)
		else $error("scheme 11 not usb");

	a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (RST)
		(fixed_device_port_mask_reg & ~HPC_MASK_PORTS) == 8'h00
		&& (assign_led_string_config_reg & ~HPC_MASK_ASSIGN_LED) == 8'h00)
		else $error("reserved bits set");

	a_strap_fixed: assert property (@(posedge REF_CLK) disable iff (RST)
		defaults_sync && strap_taken_reg
		|=> FIXED_DEVICE_PORTS == $past(fixed_strap_mask))
		else $error("strap fixed-device mask not applied");

	a_sp_mask: assert property (@(posedge REF_CLK) disable iff (RST)
		s_load_sp ##1 s_sp_used |=> PORT_OFF == $past(CFG_WR.data[4:1], 2))
		else $error("self-powered mask not applied");

	a_bp_mask: assert property (@(posedge REF_CLK) disable iff (RST)
		!defaults_sync && !local_sync
		|=> PORT_OFF == $past(bus_powered_port_off_mask_reg[4:1]))
		else $error("bus-powered mask not applied");

	a_attach_late: assert property (@(posedge REF_CLK) disable iff (RST)
		!applied_reg |=> !ATTACH_ALLOWED)
		else $error("attach before configuration applied");

endmodule

// >>> bench/hpc_cfg_loader.sv
// Purpose: configuration source model that loads bytes into the bank
// Assumes: one byte per write pulse, driven just after REF_CLK rises
// Notes:   skips images that a real configurer must never produce
`timescale 1ns/1ps
module hpc_cfg_loader
	import hpc_pkg::*;
#(
	parameter bit HAS_SECOND_LEDS = 1'b1
) (
	input  wire logic        clk,
	output hpc_pkg::hpc_wr_t cfg_wr,
	output logic             cfg_done
);
	initial begin
		cfg_wr = '0;
		cfg_done = 1'b0;
	end

	task automatic put(input logic [7:0] addr, input logic [7:0] data);
		logic [3:0] ports;
		ports = data[4:1];
		// speed scheme needs the second bank
		if (addr == HPC_ADDR_ASSIGN_LED && data[2:1] == 2'b01
			&& !HAS_SECOND_LEDS)
			return;
		// off ports contiguous from port 4
		if ((addr == HPC_ADDR_SP_OFF || addr == HPC_ADDR_BP_OFF)
			&& !(ports inside {4'h0, 4'h8, 4'hC, 4'hE, 4'hF}))
			return;
		@(posedge clk);
		cfg_wr <= '{en: 1'b1, addr: addr, data: data};
		@(posedge clk);
		// released bus shows inverted contents, never the last byte
		cfg_wr <= '{en: 1'b0, addr: ~addr, data: ~data};
	endtask

	task automatic finish();
		@(posedge clk);
		cfg_done <= 1'b1;
		@(posedge clk);
		cfg_done <= 1'b0;
	endtask
endmodule

// >>> bench/hub_port_config_bank_test.sv
// Purpose: self-checking bench for the port configuration bank
// Assumes: loader model writes, bench reads and drives the pins
// Notes:   pin effects are judged five edges after each change
`timescale 1ns/1ps
module hub_port_config_bank_test;
	import hpc_pkg::*;
	logic             ref_clk;
	logic             rst;
	hpc_wr_t          cfg_wr;
	hpc_rd_t          cfg_rd;
	logic             cfg_done;
	logic             use_defaults;
	logic [1:0]       fixed_straps;
	logic [1:0]       off_straps;
	logic             local_power;
	logic [3:0]       assign_pins;
	logic [7:0]       rdata;
	logic             rvalid;
	logic [2:0]       preset_sel;
	logic [3:0]       assigned;
	logic [3:0]       host;
	logic             from_regs;
	logic [1:0]       scheme;
	logic             string_en;
	logic [3:0]       fixed_ports;
	logic [3:0]       port_off;
	logic             self_powered;
	logic             attach;
	int               n_fail;
	int               cmp_count;

	hpc_top hpc_top_i (
		.REF_CLK(ref_clk), .RST(rst), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
		.CFG_DONE(cfg_done), .USE_DEFAULTS(use_defaults),
		.FIXED_DEVICE_STRAPS(fixed_straps), .PORT_OFF_STRAPS(off_straps),
		.LOCAL_POWER_PRESENT(local_power), .ASSIGN_PINS(assign_pins),
		.CFG_RDATA(rdata), .CFG_RVALID(rvalid), .PRESET_SEL(preset_sel),
		.PORT_ASSIGNED(assigned), .PORT_HOST(host),
		.OWNER_FROM_REGS(from_regs), .INDICATOR_SCHEME(scheme),
		.STRING_ENABLE(string_en), .FIXED_DEVICE_PORTS(fixed_ports),
		.PORT_OFF(port_off), .SELF_POWERED(self_powered),
		.ATTACH_ALLOWED(attach)
	);

	hpc_cfg_loader hpc_cfg_loader_i (
		.clk(ref_clk), .cfg_wr(cfg_wr), .cfg_done(cfg_done)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: read %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: out %h want %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic pin(input logic [3:0] v);
		@(posedge ref_clk);
		assign_pins <= v;
		step(5);
	endtask

	// answer stands one cycle after the request edge
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge ref_clk);
		cfg_rd <= '{en: 1'b1, addr: addr};
		@(posedge ref_clk);
		cfg_rd <= '{en: 1'b0, addr: ~addr};
		#1;
		chk_out({3'b000, rvalid}, 4'h1);
		chk_reg(rdata, exp);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reads only once out of reset: read valid is held low in reset
	task automatic t_reset(input bit live);
		chk_out(assigned, 4'hF);
		chk_out({3'b000, attach}, 4'h0);
		if (live) begin
			rd(HPC_ADDR_ASSIGN_LED, 8'h00);
			rd(HPC_ADDR_FIXED_DEV, 8'h00);
			rd(HPC_ADDR_SP_OFF, 8'h00);
			rd(HPC_ADDR_BP_OFF, 8'h00);
			rd(8'h0C, 8'h00);
		end
	endtask

	task automatic t_styles();
		hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, 8'hC0);
		step(2);
		pin(4'h1);
		chk_out({2'b00, assigned[0], host[0]}, 4'h3);
		pin(4'h0);
		pin(4'h1);
		chk_out(assigned, 4'hE);
		pin(4'h0);
		pin(4'h1);
		chk_out({2'b00, assigned[0], host[0]}, 4'h2);
		pin(4'h0);
		hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, 8'h80);
		step(2);
		pin(4'h1);
		chk_out({2'b00, assigned[0], host[0]}, 4'h3);
		pin(4'h0);
		pin(4'h1);
		chk_out({2'b00, assigned[0], host[0]}, 4'h2);
		chk_out(assigned, 4'hF);
		hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, 8'h40);
		pin(4'hA);
		chk_out(host, 4'hA);
		chk_out(assigned, 4'hF);
		hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, 8'h60);
		step(3);
		chk_out({3'b000, from_regs}, 4'h1);
		pin(4'h5);
		chk_out(host, 4'hA);
		hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, 8'h00);
		pin(4'h6);
		chk_out({1'b0, preset_sel}, 4'h6);
		pin(4'h3);
		chk_out({1'b0, preset_sel}, 4'h3);
		chk_out({3'b000, from_regs}, 4'h0);
	endtask

	task automatic t_fields();
		logic [1:0] code;
		for (int i = 0; i < 4; i++) begin
			code = 2'(i);
			hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, {5'b00000, code, 1'b1});
			step(3);
			chk_out({2'b00, scheme}, (code == 2'b11) ? 4'h0 : {2'b00, code});
			chk_out({3'b000, string_en}, 4'h1);
		end
		hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, 8'hFF);
		rd(HPC_ADDR_ASSIGN_LED, 8'hE7);
		hpc_cfg_loader_i.put(HPC_ADDR_ASSIGN_LED, 8'h00);
		step(3);
		chk_out({3'b000, string_en}, 4'h0);
		hpc_cfg_loader_i.put(HPC_ADDR_FIXED_DEV, 8'hFF);
		rd(HPC_ADDR_FIXED_DEV, 8'h1E);
		chk_out(fixed_ports, 4'hF);
		// self powered before the load, so load-to-use is exercised
		@(posedge ref_clk);
		local_power <= 1'b1;
		step(3);
		hpc_cfg_loader_i.put(HPC_ADDR_SP_OFF, 8'hF9);
		hpc_cfg_loader_i.put(HPC_ADDR_BP_OFF, 8'h1D);
		rd(HPC_ADDR_SP_OFF, 8'h18);
		rd(HPC_ADDR_BP_OFF, 8'h1C);
		chk_out(port_off, 4'hC);
		chk_out({3'b000, self_powered}, 4'h1);
		@(posedge ref_clk);
		local_power <= 1'b0;
		step(5);
		chk_out(port_off, 4'hE);
		chk_out({3'b000, self_powered}, 4'h0);
	endtask

	task automatic t_apply();
		hpc_cfg_loader_i.finish();
		#1;
		chk_out({3'b000, attach}, 4'h0);
		step(1);
		chk_out({3'b000, attach}, 4'h1);
		hpc_cfg_loader_i.put(HPC_ADDR_FIXED_DEV, 8'h00);
		rd(HPC_ADDR_FIXED_DEV, 8'h1E);
	endtask

	task automatic t_defaults();
		@(posedge ref_clk);
		rst <= 1'b1;
		use_defaults <= 1'b1;
		fixed_straps <= 2'b10;
		off_straps <= 2'b11;
		step(2);
		chk_out(assigned, 4'hF);
		chk_out({3'b000, attach}, 4'h0);
		@(posedge ref_clk);
		rst <= 1'b0;
		step(5);
		chk_out(fixed_ports, 4'h3);
		chk_out(port_off, 4'hE);
		rd(HPC_ADDR_SP_OFF, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_fail = 0;
		cmp_count = 0;
		rst = 1'b1;
		cfg_rd = '0;
		use_defaults = 1'b0;
		fixed_straps = 2'b00;
		off_straps = 2'b00;
		local_power = 1'b0;
		assign_pins = 4'h0;
		step(5);
		t_reset(1'b0);
		@(posedge ref_clk);
		rst <= 1'b0;
		step(3);
		t_reset(1'b1);
		t_styles();
		t_fields();
		t_apply();
		t_defaults();
		summarize();
	end
endmodule
